// ==== core/backup_timekeeper.sv ====
/*
  Backup timekeeper with paged serial register access, setup and command bytes.
  Assumes serial pins come from another domain and a 10 MHz sys_clk that stays up on backup power.
*/
// Contract
// RL1: Setup bit 0 selects elapsed timer (0) or clock/calendar (1).
// RL2: Elapsed mode starts all time words at zero after reset and counts on.
// RL3: Software writes seconds, minutes, hours, day, month, then year.
// RL4: Written time stays pending until the year byte is written.
// RL5: Loaded time appears from the next one-second tick onward.
// RL6: Software always writes the year byte last, even if unchanged.
// RL7: Software sets calendar mode before writing time.
// RL8: Setup bit 1 is the daylight saving control.
// RL9: Software triggers flash update with command bit 3 after setup.
// RL10: Counting continues on backup power; reads need main power and startup.
// RL11: Seconds in bits 5:0, binary 0 to 59.
// RL12: Minutes in bits 13:8, binary 0 to 59.
// RL13: Hours in bits 5:0 of day/hour word, 0 to 23.
// RL14: Day in bits 12:8, 1 to 31.
// RL15: Month in bits 3:0 of year/month word, 1 to 12.
// RL16: Year in bits 14:8, 0 to 99 from 2000.
// RL17: Command bits set by software clear themselves when done.
// RL18: Calendar ticks carry seconds up to year with month lengths.
// RL19: The second tick comes from the backup-domain timebase.
`timescale 1ns/100ps
`include "timekeeper_map.svh"

module backup_timekeeper #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned FLASH_CYCLES = `FLASH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic main_ready,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic calendar_mode,
  output logic dst_enable,
  output logic flash_update_req,
  output logic flash_busy,
  output logic second_tick
);
  import timekeeper_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, mosi_s1, mosi_s2, main_s1, main_s2;

  // Two flops per pin, third only for edge detection
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      main_s1 <= 1'b0; // Supply flag starts absent
      main_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      mosi_s1 <= mosi;
      mosi_s2 <= mosi_s1;
      main_s1 <= main_ready;
      main_s2 <= main_s1;
    end
  end

  logic sclk_rise, sclk_fall, frame_start, frame_end;
  assign sclk_rise = sclk_s2 && !sclk_s3 && !cs_s2;
  assign sclk_fall = !sclk_s2 && sclk_s3 && !cs_s2;
  assign frame_start = !cs_s2 && cs_s3;
  assign frame_end = cs_s2 && !cs_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame shifter

  logic [15:0] rx_reg, rx_next, tx_reg, tx_next, rd_data_reg, rd_data_next;
  logic [4:0] bits_reg, bits_next;
  logic frame_ok, wr_frame, rd_frame;
  logic [6:0] frame_addr;
  logic [7:0] frame_byte;
  logic [15:0] rd_mux;

  assign frame_ok = frame_end && bits_reg == `FRAME_BITS && main_s2; // RL10
  assign wr_frame = frame_ok && rx_reg[`FRAME_WR_BIT];
  assign rd_frame = frame_ok && !rx_reg[`FRAME_WR_BIT];
  assign frame_addr = rx_reg[14:8];
  assign frame_byte = rx_reg[7:0];

  // Sample on rising edge, shift out on falling, answer on next frame
  always_comb begin
    rx_next = rx_reg;
    tx_next = tx_reg;
    bits_next = bits_reg;
    rd_data_next = rd_data_reg;
    if (frame_start) begin
      bits_next = 5'h00;
      tx_next = rd_data_reg;
    end else if (sclk_rise && bits_reg != `FRAME_BITS + 5'h01) begin // Stops at 17, refused
      rx_next = {rx_reg[14:0], mosi_s2};
      bits_next = bits_reg + 5'h01;
    end else if (sclk_fall) begin
      tx_next = {tx_reg[14:0], 1'b0};
    end
    if (rd_frame) begin
      rd_data_next = rd_mux;
    end else if (frame_ok || !main_s2) begin
      rd_data_next = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bits_reg <= 5'h00;
      rd_data_reg <= 16'h0000;
    end else begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      bits_reg <= bits_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign miso = tx_reg[15];

  ////////////////////////////////////////////////////////////////////////////
  // Page, setup, pending time and commit registers

  logic [7:0] page_reg, page_next, setup_reg, setup_next;
  logic [15:0] ms_pend_reg, ms_pend_next, dh_pend_reg, dh_pend_next, ym_pend_reg, ym_pend_next;
  logic commit_reg, commit_next, year_wr, time_page, ctrl_page;
  sec_t sec_reg;
  min_t min_reg;
  hour_t hour_reg;
  day_t day_reg;
  mon_t mon_reg;
  year_t year_reg;

  assign time_page = page_reg == `PAGE_TIME;
  assign ctrl_page = page_reg == `PAGE_CTRL;
  assign year_wr = wr_frame && time_page && frame_addr == `YEAR_BYTE_ADDR
                   && setup_reg[`SETUP_MODE_BIT]; // RL4
  assign calendar_mode = setup_reg[`SETUP_MODE_BIT]; // RL1
  assign dst_enable = setup_reg[`SETUP_DST_BIT]; // RL8

  // Byte writes into page, setup and pending words
  always_comb begin
    page_next = page_reg;
    setup_next = setup_reg;
    ms_pend_next = ms_pend_reg;
    dh_pend_next = dh_pend_reg;
    ym_pend_next = ym_pend_reg;
    commit_next = year_wr || (commit_reg && !second_tick); // RL4 RL5
    if (wr_frame) begin
      if (frame_addr == `PAGE_SEL_ADDR) begin
        page_next = frame_byte;
      end else if (ctrl_page && frame_addr == `SETUP_ADDR) begin
        setup_next = frame_byte; // RL1 RL8
      end else if (time_page && calendar_mode) begin
        case (frame_addr)
          `MIN_SEC_ADDR: ms_pend_next[7:0] = {2'h0, frame_byte[5:0]}; // RL11
          `MIN_BYTE_ADDR: ms_pend_next[15:8] = {2'h0, frame_byte[5:0]}; // RL12
          `DAY_HOUR_ADDR: dh_pend_next[7:0] = {3'h0, frame_byte[4:0]}; // RL13
          `DAY_BYTE_ADDR: dh_pend_next[15:8] = {3'h0, frame_byte[4:0]}; // RL14
          `YEAR_MON_ADDR: ym_pend_next[7:0] = {4'h0, frame_byte[3:0]}; // RL15
          `YEAR_BYTE_ADDR: ym_pend_next[15:8] = {1'b0, frame_byte[6:0]}; // RL16
          default: ym_pend_next = ym_pend_reg;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      page_reg <= `PAGE_TIME;
      setup_reg <= `SETUP_RESET;
      ms_pend_reg <= 16'h0000;
      dh_pend_reg <= 16'h0000;
      ym_pend_reg <= 16'h0000;
      commit_reg <= 1'b0;
    end else begin
      page_reg <= page_next;
      setup_reg <= setup_next;
      ms_pend_reg <= ms_pend_next;
      dh_pend_reg <= dh_pend_next;
      ym_pend_reg <= ym_pend_next;
      commit_reg <= commit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash update command, self clearing

  flash_state_t flash_state_reg, flash_state_next;
  logic [31:0] flash_cnt_reg, flash_cnt_next;
  logic flash_start;

  assign flash_start = wr_frame && ctrl_page && frame_addr == `GLOBAL_COMMAND_REGISTER_ADDR
                       && frame_byte[`CMD_FLASH_BIT];

  // Busy for the flash time, then the command bit drops
  always_comb begin
    flash_state_next = flash_state_reg;
    flash_cnt_next = flash_cnt_reg;
    case (flash_state_reg)
      FLASH_IDLE: begin
        if (flash_start) begin
          flash_state_next = FLASH_BUSY;
          flash_cnt_next = 32'h0;
        end
      end
      FLASH_BUSY: begin
        flash_cnt_next = flash_cnt_reg + 32'h1;
        if (flash_cnt_reg >= FLASH_CYCLES - 1) begin
          flash_state_next = FLASH_IDLE; // RL17
        end
      end
      default: flash_state_next = FLASH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flash_state_reg <= FLASH_IDLE;
      flash_cnt_reg <= 32'h0;
    end else begin
      flash_state_reg <= flash_state_next;
      flash_cnt_reg <= flash_cnt_next;
    end
  end

  assign flash_busy = flash_state_reg == FLASH_BUSY;
  assign flash_update_req = flash_start && flash_state_reg == FLASH_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // One-second timebase and counter

  logic [31:0] tick_cnt_reg, tick_cnt_next;

  // Free running divider, independent of main power
  always_comb begin
    tick_cnt_next = (tick_cnt_reg >= TICK_CYCLES - 1) ? 32'h0 : tick_cnt_reg + 32'h1; // RL19
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  assign second_tick = tick_cnt_reg == TICK_CYCLES - 1; // RL10

  time_counter counter_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(second_tick),
    .calendar(calendar_mode),
    .load(commit_reg), // RL5
    .load_sec(ms_pend_reg[5:0]),
    .load_min(ms_pend_reg[13:8]),
    .load_hour(dh_pend_reg[4:0]),
    .load_day(dh_pend_reg[12:8]),
    .load_mon(ym_pend_reg[3:0]),
    .load_year(ym_pend_reg[14:8]),
    .sec_reg(sec_reg),
    .min_reg(min_reg),
    .hour_reg(hour_reg),
    .day_reg(day_reg),
    .mon_reg(mon_reg),
    .year_reg(year_reg)
  );

  // Read data selection by page and address
  always_comb begin
    rd_mux = 16'h0000;
    if (frame_addr == `PAGE_SEL_ADDR) begin
      rd_mux = {8'h00, page_reg};
    end else if (time_page) begin
      case (frame_addr)
        `MIN_SEC_ADDR: rd_mux = {2'h0, min_reg, 2'h0, sec_reg}; // RL11 RL12
        `DAY_HOUR_ADDR: rd_mux = {3'h0, day_reg, 3'h0, hour_reg}; // RL13 RL14
        `YEAR_MON_ADDR: rd_mux = {1'b0, year_reg, 4'h0, mon_reg}; // RL15 RL16
        default: rd_mux = 16'h0000;
      endcase
    end else if (ctrl_page) begin
      case (frame_addr)
        `SETUP_ADDR: rd_mux = {8'h00, setup_reg};
        `GLOBAL_COMMAND_REGISTER_ADDR: rd_mux = {12'h000, flash_busy, 3'h0}; // RL17
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  commit_hold_a: assert property (commit_reg && !second_tick |=> commit_reg)
    else $error("pending commit dropped early"); // RL4
  commit_load_a: assert property (commit_reg && second_tick |=>
    sec_reg == $past(ms_pend_reg[5:0]) && year_reg == $past(ym_pend_reg[14:8]))
    else $error("commit not loaded on tick"); // RL5
  no_commit_a: assert property (!commit_reg && second_tick && sec_reg < `SEC_MAX |=>
    sec_reg == $past(sec_reg) + 6'h01) else $error("seconds did not advance"); // RL2
  tick_gap_a: assert property (second_tick |=> !second_tick)
    else $error("tick lasted more than one cycle"); // RL19
  flash_clear_a: assert property (flash_update_req |=> flash_busy[*8])
    else $error("flash busy too short"); // RL17
  flash_done_a: assert property (flash_busy && flash_cnt_reg == FLASH_CYCLES - 1 |=> !flash_busy)
    else $error("flash bit did not clear"); // RL17
  read_gate_a: assert property (!main_s2 |=> rd_data_reg == 16'h0000)
    else $error("read data without main power"); // RL10
  mode_out_a: assert property (wr_frame && ctrl_page && frame_addr == `SETUP_ADDR |=>
    calendar_mode == $past(frame_byte[0])) else $error("mode bit not taken"); // RL1
endmodule

// ==== core/time_counter.sv ====
/*
  Seconds-to-year counter with carry chain, month lengths and a commit load.
  Assumes a one-cycle tick per second and load values held stable by the caller.
*/
`timescale 1ns/100ps
`include "timekeeper_map.svh"

module time_counter (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic calendar,
  input wire logic load,
  input wire timekeeper_pkg::sec_t load_sec,
  input wire timekeeper_pkg::min_t load_min,
  input wire timekeeper_pkg::hour_t load_hour,
  input wire timekeeper_pkg::day_t load_day,
  input wire timekeeper_pkg::mon_t load_mon,
  input wire timekeeper_pkg::year_t load_year,
  output timekeeper_pkg::sec_t sec_reg,
  output timekeeper_pkg::min_t min_reg,
  output timekeeper_pkg::hour_t hour_reg,
  output timekeeper_pkg::day_t day_reg,
  output timekeeper_pkg::mon_t mon_reg,
  output timekeeper_pkg::year_t year_reg
);
  import timekeeper_pkg::*;

  sec_t sec_next;
  min_t min_next;
  hour_t hour_next;
  day_t day_next;
  mon_t mon_next;
  year_t year_next;
  day_t last_day;

  // Days in the current month, leap every fourth year from 2000
  always_comb begin
    case (mon_reg)
      4'h4, 4'h6, 4'h9, 4'hB: last_day = 5'h1E;
      `MON_FEB: last_day = (year_reg[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      default: last_day = `DAY_MAX;
    endcase
  end

  // Load on commit tick, else carry through the fields
  always_comb begin
    sec_next = sec_reg;
    min_next = min_reg;
    hour_next = hour_reg;
    day_next = day_reg;
    mon_next = mon_reg;
    year_next = year_reg;
    if (tick && load) begin
      sec_next = load_sec;
      min_next = load_min;
      hour_next = load_hour;
      day_next = load_day;
      mon_next = load_mon;
      year_next = load_year;
    end else if (tick) begin
      sec_next = sec_reg + 6'h01;
      if (sec_reg >= `SEC_MAX) begin // RL11 RL18
        sec_next = 6'h00;
        min_next = min_reg + 6'h01;
        if (min_reg >= `MIN_MAX) begin // RL12
          min_next = 6'h00;
          hour_next = hour_reg + 5'h01;
          if (hour_reg >= `HOUR_MAX) begin // RL13
            hour_next = 5'h00;
            day_next = day_reg + 5'h01;
            if (calendar ? (day_reg >= last_day) : (day_reg >= `DAY_MAX)) begin // RL14
              day_next = calendar ? `DAY_FIRST : 5'h00;
              mon_next = mon_reg + 4'h1;
              if (mon_reg >= (calendar ? `MON_MAX : `MON_MAX - 4'h1)) begin // RL15
                mon_next = calendar ? `MON_FIRST : 4'h0;
                year_next = (year_reg >= `YEAR_MAX) ? 7'h00 : year_reg + 7'h01; // RL16
              end
            end
          end
        end
      end
    end
  end

  // Time state, all zero after reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sec_reg <= 6'h00; // RL2
      min_reg <= 6'h00;
      hour_reg <= 5'h00;
      day_reg <= 5'h00;
      mon_reg <= 4'h0;
      year_reg <= 7'h00;
    end else begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      day_reg <= day_next;
      mon_reg <= mon_next;
      year_reg <= year_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sec_range_a: assert property (sec_reg <= `SEC_MAX) else $error("seconds out of range"); // RL11
  min_range_a: assert property (min_reg <= `MIN_MAX) else $error("minutes out of range"); // RL12
  hour_range_a: assert property (hour_reg <= `HOUR_MAX) else $error("hours out of range"); // RL13
  still_no_tick_a: assert property (!tick |=> $stable(sec_reg) && $stable(year_reg))
    else $error("time moved without tick"); // RL18
  sec_carry_a: assert property (tick && !load && sec_reg == `SEC_MAX |=>
    sec_reg == 6'h00 && min_reg != $past(min_reg)) else $error("seconds carry lost"); // RL18
endmodule

// ==== core/timekeeper_map.svh ====
/*
  Register offsets, field positions, limits and timing figures of the backup timekeeper.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef TIMEKEEPER_MAP_SVH
`define TIMEKEEPER_MAP_SVH

// Page selector and page numbers
`define PAGE_SEL_ADDR 7'h00
`define PAGE_TIME 8'h00
`define PAGE_CTRL 8'h03

// Page 0 time words, byte addresses
`define MIN_SEC_ADDR 7'h78
`define MIN_BYTE_ADDR 7'h79
`define DAY_HOUR_ADDR 7'h7A
`define DAY_BYTE_ADDR 7'h7B
`define YEAR_MON_ADDR 7'h7C
`define YEAR_BYTE_ADDR 7'h7D

// Page 3 control bytes
`define GLOBAL_COMMAND_REGISTER_ADDR 7'h02
`define SETUP_ADDR 7'h0A
`define SETUP_MODE_BIT 0
`define SETUP_DST_BIT 1
`define CMD_FLASH_BIT 3
`define SETUP_RESET 8'h00

// Field limits
`define SEC_MAX 6'h3B
`define MIN_MAX 6'h3B
`define HOUR_MAX 5'h17
`define DAY_MAX 5'h1F
`define DAY_FIRST 5'h01
`define MON_MAX 4'hC
`define MON_FIRST 4'h1
`define MON_FEB 4'h2
`define YEAR_MAX 7'h63

// Frame layout
`define FRAME_BITS 5'h10
`define FRAME_WR_BIT 15

// Timing: clock rate, one second, flash update time
`define CLK_HZ 10000000
`define TICK_MS 1000
`define FLASH_MS 375
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`define FLASH_CYCLES (`CLK_HZ / 1000 * `FLASH_MS)

`endif

// ==== core/timekeeper_pkg.sv ====
/*
  Types shared by the timekeeper modules.
  Assumes the constants header sits beside it.
*/
`include "timekeeper_map.svh"

package timekeeper_pkg;
  typedef logic [5:0] sec_t;
  typedef logic [5:0] min_t;
  typedef logic [4:0] hour_t;
  typedef logic [4:0] day_t;
  typedef logic [3:0] mon_t;
  typedef logic [6:0] year_t;
  typedef enum logic [0:0] {
    FLASH_IDLE = 1'b0,
    FLASH_BUSY = 1'b1
  } flash_state_t;
endpackage

// ==== dv/backup_timekeeper_test.sv ====
/*
  Self-checking bench for the backup timekeeper: serial frames, modes, commit and flash command.
  Assumes the core package and design modules are compiled first; the bench drives every pin.
*/
`timescale 1ns/100ps

module backup_timekeeper_test;
  import timekeeper_pkg::*;
  localparam int TICK = 1500;
  localparam int FLASH = 1000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic main_ready = 1'b1;
  logic sclk = 1'b1;
  logic cs_n = 1'b1;
  logic mosi = 1'b0;
  logic miso;
  logic calendar_mode;
  logic dst_enable;
  logic flash_update_req;
  logic flash_busy;
  logic second_tick;
  int err_total = 0;
  int n_checks = 0;
  int n_ticks = 0;
  int n_flash = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and device under test
  always #50 sys_clk = ~sys_clk;

  backup_timekeeper #(
    .TICK_CYCLES(TICK),
    .FLASH_CYCLES(FLASH)
  ) i_backup_timekeeper (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .main_ready(main_ready),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .calendar_mode(calendar_mode),
    .dst_enable(dst_enable),
    .flash_update_req(flash_update_req),
    .flash_busy(flash_busy),
    .second_tick(second_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Count second ticks and flash start pulses
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      n_ticks <= 0;
      n_flash <= 0;
    end else begin
      if (second_tick === 1'b1) n_ticks <= n_ticks + 1;
      if (flash_update_req === 1'b1) n_flash <= n_flash + 1;
    end
  end

  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total = err_total + 1;
      $display("FAIL %0t run too long", $time);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One 16-bit frame, mode 3, read bits taken before each falling sclk
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    cyc(6);
    for (int i = 15; i >= 0; i--) begin
      @(negedge sys_clk);
      rx = {rx[14:0], miso};
      @(posedge sys_clk);
      sclk <= 1'b0;
      mosi <= tx[i];
      cyc(4);
      sclk <= 1'b1;
      cyc(3);
    end
    cyc(2);
    cs_n <= 1'b1;
    cyc(8);
  endtask

  task automatic wr(input logic [15:0] tx);
    logic [15:0] junk;
    xfer(tx, junk);
  endtask

  task automatic read_word(input logic [6:0] addr, output logic [15:0] rx);
    logic [15:0] junk;
    xfer({1'b0, addr, 8'h00}, junk);
    xfer(16'h0000, rx);
  endtask

  // Returns two edges after a tick, when the time words have moved
  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (second_tick !== 1'b1 && k < 2 * TICK);
    if (second_tick !== 1'b1) begin
      err_total = err_total + 1;
      $display("FAIL %0t no second tick", $time);
    end
    cyc(2);
  endtask

  // Pipelined read of the three time words
  task automatic check_time(input int s, input int m, input int h, input int d,
                            input int mo, input int y);
    logic [15:0] junk;
    logic [15:0] ms;
    logic [15:0] dh;
    logic [15:0] ym;
    xfer(16'h7800, junk);
    xfer(16'h7A00, ms);
    xfer(16'h7C00, dh);
    xfer(16'h0000, ym);
    check16(ms, {2'h0, 6'(m), 2'h0, 6'(s)});
    check16(dh, {3'h0, 5'(d), 2'h0, 6'(h)});
    check16(ym, {1'h0, 7'(y), 4'h0, 4'(mo)});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic elapsed_mode();
    wr(16'hF805);
    wr(16'hFD05);
    wait_tick();
    wait_tick();
    check_time(n_ticks % 60, 0, 0, 0, 0, 0);
  endtask

  task automatic setup_and_flash();
    logic [15:0] r;
    wr(16'h8003);
    wr(16'h8A03);
    check16({14'h0, dst_enable, calendar_mode}, 16'h0003);
    read_word(7'h0A, r);
    check16(r, 16'h0003);
    wr(16'h8A01);
    check16({14'h0, dst_enable, calendar_mode}, 16'h0001);
    wr(16'h8208);
    wr(16'h8208);
    check16({15'h0, flash_busy}, 16'h0001);
    check16(16'(n_flash), 16'h0001);
    read_word(7'h02, r);
    check16(r, 16'h0008);
    cyc(FLASH);
    check16({15'h0, flash_busy}, 16'h0000);
    read_word(7'h02, r);
    check16(r, 16'h0000);
    read_word(7'h40, r);
    check16(r, 16'h0000);
    wr(16'h8000);
  endtask

  // Fields written without the year byte must not move the count
  task automatic pending_writes();
    wait_tick();
    wr(16'hF81E);
    wr(16'hF91E);
    wr(16'hFA05);
    wr(16'hFB05);
    wr(16'hFC05);
    wait_tick();
    check_time(n_ticks % 60, 0, 0, 0, 0, 0);
  endtask

  // Load in documented order, see it at the next tick, then one carry later
  task automatic load_case(input int s, input int m, input int h, input int d, input int mo,
                           input int y, input int ns, input int nm, input int nh,
                           input int nd, input int nmo, input int ny);
    wait_tick();
    wr({8'hF8, 2'h0, 6'(s)});
    wr({8'hF9, 2'h0, 6'(m)});
    wr({8'hFA, 2'h0, 6'(h)});
    wr({8'hFB, 3'h0, 5'(d)});
    wr({8'hFC, 4'h0, 4'(mo)});
    wr({8'hFD, 1'h0, 7'(y)});
    wait_tick();
    check_time(s, m, h, d, mo, y);
    wait_tick();
    check_time(ns, nm, nh, nd, nmo, ny);
  endtask

  // Main supply away: frames ignored, count goes on
  task automatic backup_count();
    main_ready <= 1'b0;
    wr(16'hFD63);
    wait_tick();
    wait_tick();
    main_ready <= 1'b1;
    cyc(4);
    check_time(2, 0, 23, 15, 6, 10);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(3);
    check16({13'h0, calendar_mode, dst_enable, flash_busy}, 16'h0000);
    elapsed_mode();
    setup_and_flash();
    pending_writes();
    load_case(59, 59, 23, 31, 12, 99, 0, 0, 0, 1, 1, 0);
    load_case(59, 59, 23, 28, 2, 4, 0, 0, 0, 29, 2, 4);
    load_case(59, 59, 23, 28, 2, 5, 0, 0, 0, 1, 3, 5);
    load_case(59, 59, 23, 30, 4, 7, 0, 0, 0, 1, 5, 7);
    load_case(59, 59, 22, 15, 6, 10, 0, 0, 23, 15, 6, 10);
    backup_count();
    finish_test();
  end
endmodule
